// >>> etc_params.svh
// Constants of the elapsed time capture counter: widths, codes, ratios and reset values.
`ifndef ETC_PARAMS_SVH
`define ETC_PARAMS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define ETC_COUNT_WIDTH 40
`define ETC_BYTE_COUNT 5
`define ETC_PIN_COUNT 4
`define ETC_FUNC_WIDTH 6
`define ETC_DIV_WIDTH 5

// ****************************************************************
// Codes and ratios
// ****************************************************************
`define ETC_FUNC_CAPTURE_TRIGGER 6'h27
`define ETC_VCO_SEL_THIRD_PLL 1'h0
`define ETC_VCO_SEL_SECOND_PLL 1'h1
`define ETC_TRIG_SEL_CHIP_SELECT 1'h0
`define ETC_TRIG_SEL_PIN 1'h1
`define ETC_DIV_THIRD_PLL 5'h08
`define ETC_DIV_SECOND_PLL 5'h14

// ****************************************************************
// Reset values and synchroniser depth
// ****************************************************************
`define ETC_COUNT_RESET 40'h00_0000_0000
`define ETC_DIV_RESET 5'h00
`define ETC_SYNC_STAGES 2

`endif

// >>> etc_pkg.sv
// Types shared by the elapsed time capture counter.
`default_nettype none
`include "etc_params.svh"

package etc_pkg;

    // Capture lock: armed takes captures, held keeps the field for software.
    typedef enum logic [1:0]
    {
        ETC_ARMED = 2'b01,
        ETC_HELD = 2'b10
    } etc_lock_e;

    typedef logic [`ETC_COUNT_WIDTH-1:0] etc_count_t;
    typedef logic [`ETC_PIN_COUNT-1:0] etc_pins_t;
    typedef logic [`ETC_FUNC_WIDTH-1:0] etc_func_t;
    typedef logic [`ETC_DIV_WIDTH-1:0] etc_div_t;

    // State of the counter block, apart from the input synchroniser stages.
    typedef struct packed
    {
        etc_lock_e lock;
        etc_div_t div;
        etc_count_t count;
        etc_count_t captured;
        etc_pins_t pin_prev;
        logic cs_prev_n;
        logic cap_pulse;
    } etc_state_s;

endpackage : etc_pkg

`default_nettype wire

// >>> etc_sync.sv
// Two-stage level synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none

module etc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous levels in
    input wire logic [WIDTH-1:0] async_in,
    // Synchronised levels out
    output logic [WIDTH-1:0] sync_out
);

    // ****************************************************************
    // Synchroniser stages
    // ****************************************************************
    // The first stage feeds only the second; nothing else looks at it.
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stable_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= RESET_VAL;
            stable_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= async_in;
            stable_q <= meta_q;
        end
    end

    assign sync_out = stable_q;

endmodule : etc_sync

`default_nettype wire

// >>> etc_capture_counter.sv
// Elapsed time counter with pin or chip-select triggered capture.
`timescale 1ns/1ps
`default_nettype none
`include "etc_params.svh"

module etc_capture_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,

    // Configuration levels
    input wire logic count_enable_bit,
    input wire logic trigger_source_select,
    input wire logic counter_vco_select,

    // Trigger pins and their configuration
    input wire logic [`ETC_PIN_COUNT-1:0] trigger_pins,
    input wire logic [`ETC_PIN_COUNT-1:0][`ETC_FUNC_WIDTH-1:0] pin_function_select,
    input wire logic [`ETC_PIN_COUNT-1:0] pin_polarity_invert,

    // Serial port chip select pin, active low
    input wire logic serial_chip_select_n,

    // Read strobes from the serial register logic, one cycle each
    input wire logic lsb_read_strobe,
    input wire logic msb_read_strobe,

    // Captured field and status
    output logic [`ETC_COUNT_WIDTH-1:0] captured_count_field,
    output logic [`ETC_BYTE_COUNT-1:0][7:0] captured_count_bytes,
    output logic [`ETC_COUNT_WIDTH-1:0] elapsed_time_counter,
    output logic capture_held,
    output logic capture_pulse,
    output logic counter_tick
);

    import etc_pkg::*;

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    // Pins and chip select are asynchronous to clk. Two stages cost up to
    // two clk cycles of latency, which is well under one counter period at
    // the slowest division, so capture uncertainty stays at one tick.
    localparam int SYNC_W = `ETC_PIN_COUNT + 1;
    localparam logic [SYNC_W-1:0] SYNC_RESET = {1'b1, {`ETC_PIN_COUNT{1'b0}}};

    logic [SYNC_W-1:0] sync_levels;
    etc_pins_t pins_s;
    logic cs_s_n;

    etc_sync #(
        .WIDTH(SYNC_W),
        .RESET_VAL(SYNC_RESET)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({serial_chip_select_n, trigger_pins}),
        .sync_out(sync_levels)
    );

    assign pins_s = sync_levels[`ETC_PIN_COUNT-1:0];
    assign cs_s_n = sync_levels[SYNC_W-1];

    // ****************************************************************
    // State registers
    // ****************************************************************
    localparam etc_state_s STATE_RESET = '{
        lock: ETC_ARMED,
        div: `ETC_DIV_RESET,
        count: `ETC_COUNT_RESET,
        captured: `ETC_COUNT_RESET,
        pin_prev: '0,
        cs_prev_n: 1'b1,
        cap_pulse: 1'b0
    };

    etc_state_s state_q;
    etc_state_s state_d;

    // ****************************************************************
    // Per-pin edge detection
    // ****************************************************************
    etc_pins_t pin_hit;

    genvar gi;
    generate
        for (gi = 0; gi < `ETC_PIN_COUNT; gi = gi + 1)
        begin : g_pin
            logic is_trigger;
            logic rise;
            logic fall;

            // Only pins given the capture trigger function take part.
            assign is_trigger = (pin_function_select[gi] == `ETC_FUNC_CAPTURE_TRIGGER);
            assign rise = pins_s[gi] & ~state_q.pin_prev[gi];
            assign fall = ~pins_s[gi] & state_q.pin_prev[gi];
            // Rising edge by default; invert turns it into the falling edge.
            assign pin_hit[gi] = is_trigger & (pin_polarity_invert[gi] ? fall : rise);
        end
    endgenerate

    // ****************************************************************
    // Counter clock divider
    // ****************************************************************
    etc_div_t div_ratio;
    logic tick;

    always_comb
    begin
        if (counter_vco_select == `ETC_VCO_SEL_SECOND_PLL)
        begin
            div_ratio = `ETC_DIV_SECOND_PLL;
        end
        else
        begin
            div_ratio = `ETC_DIV_THIRD_PLL;
        end
    end

    // One-cycle enable at the divided rate stands in for the counter clock.
    assign tick = count_enable_bit && (state_q.div == div_ratio - `ETC_DIV_WIDTH'(1));

    // ****************************************************************
    // Trigger selection
    // ****************************************************************
    logic cs_fall;
    logic pin_event;
    logic cs_event;
    logic take_capture;
    logic set_hold;

    assign cs_fall = state_q.cs_prev_n & ~cs_s_n;

    // Exactly one source is live; the other is ignored entirely.
    assign pin_event = (trigger_source_select == `ETC_TRIG_SEL_PIN) && (|pin_hit);
    assign cs_event = (trigger_source_select == `ETC_TRIG_SEL_CHIP_SELECT) && cs_fall;

    // Captures need the counter enabled and capture armed.
    assign take_capture = count_enable_bit && (state_q.lock == ETC_ARMED)
        && (pin_event || cs_event);

    // A pin capture locks at once; a chip-select capture only locks once
    // software has read the high byte of the field.
    assign set_hold = (take_capture && pin_event) || msb_read_strobe;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        state_d = state_q;
        state_d.pin_prev = pins_s;
        state_d.cs_prev_n = cs_s_n;
        state_d.cap_pulse = 1'b0;

        // Counter and divider.
        if (!count_enable_bit)
        begin
            state_d.div = `ETC_DIV_RESET;
            state_d.count = `ETC_COUNT_RESET;
        end
        else if (tick)
        begin
            state_d.div = `ETC_DIV_RESET;
            // Natural 40-bit overflow gives the wrap to zero.
            state_d.count = state_q.count + `ETC_COUNT_WIDTH'(1);
        end
        else
        begin
            state_d.div = state_q.div + `ETC_DIV_WIDTH'(1);
        end

        // Capture of the running count.
        if (take_capture)
        begin
            state_d.captured = state_q.count;
            state_d.cap_pulse = 1'b1;
        end

        // Lock: a hold request in the same cycle as the low-byte read wins,
        // so a capture is never released before software has seen it. A
        // multibyte read that covers high then low byte ends armed.
        unique case (state_q.lock)
            ETC_ARMED:
            begin
                if (set_hold)
                begin
                    state_d.lock = ETC_HELD;
                end
            end
            ETC_HELD:
            begin
                if (lsb_read_strobe && !set_hold)
                begin
                    state_d.lock = ETC_ARMED;
                end
            end
            default:
            begin
                state_d.lock = ETC_ARMED;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= STATE_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign captured_count_field = state_q.captured;
    assign elapsed_time_counter = state_q.count;
    assign capture_held = (state_q.lock == ETC_HELD);
    assign capture_pulse = state_q.cap_pulse;
    assign counter_tick = tick;

    // Byte 0 is the high byte, byte 4 the low byte, in read order.
    generate
        for (gi = 0; gi < `ETC_BYTE_COUNT; gi = gi + 1)
        begin : g_byte
            assign captured_count_bytes[gi] =
                state_q.captured[`ETC_COUNT_WIDTH-1-8*gi -: 8];
        end
    endgenerate

endmodule : etc_capture_counter

`default_nettype wire

// >>> etc_capture_counter_checker.sv
// Port assertions and covers of the elapsed time capture counter.
`timescale 1ns/1ps
`default_nettype none

module etc_capture_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched ports
    input wire logic count_enable_bit,
    input wire logic counter_vco_select,
    input wire logic lsb_read_strobe,
    input wire logic msb_read_strobe,
    input wire logic [39:0] captured_count_field,
    input wire logic [4:0][7:0] captured_count_bytes,
    input wire logic [39:0] elapsed_time_counter,
    input wire logic capture_held,
    input wire logic capture_pulse,
    input wire logic counter_tick
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_field_cause: assert property ($changed(captured_count_field) |-> capture_pulse)
        else $error("field moved with no capture");
    chk_capture_value: assert property (capture_pulse |->
        captured_count_field == $past(elapsed_time_counter)) else $error("wrong captured value");
    chk_disabled_zero: assert property (!count_enable_bit |=> elapsed_time_counter == 40'h0)
        else $error("count not held at zero");
    chk_tick_step: assert property (count_enable_bit && counter_tick |=>
        elapsed_time_counter == $past(elapsed_time_counter) + 40'h1) else $error("bad step");
    chk_tick_ratio: assert property (count_enable_bit && !counter_vco_select && counter_tick
        ##1 (count_enable_bit && !counter_vco_select) [*8] |-> counter_tick)
        else $error("tick spacing not eight");
    chk_held_blocks: assert property (capture_held |=> !capture_pulse)
        else $error("capture while held");
    chk_lsb_rearm: assert property (capture_held && lsb_read_strobe && !msb_read_strobe
        |=> !capture_held) else $error("low byte read did not re-arm");
    chk_msb_lock: assert property (msb_read_strobe |=> capture_held)
        else $error("high byte read did not lock");
    chk_byte_order: assert property (captured_count_bytes[0] == captured_count_field[39:32]
        && captured_count_bytes[4] == captured_count_field[7:0]) else $error("byte order");

    cover property (capture_pulse && capture_held);
    cover property (capture_held && lsb_read_strobe);
    cover property (counter_tick && counter_vco_select);
endmodule : etc_capture_checker

bind etc_capture_counter etc_capture_checker etc_capture_checker_inst (.clk, .rst_n,
    .count_enable_bit, .counter_vco_select, .lsb_read_strobe, .msb_read_strobe,
    .captured_count_field, .captured_count_bytes, .elapsed_time_counter, .capture_held,
    .capture_pulse, .counter_tick);

`default_nettype wire

// >>> etc_host_model.sv
// Serial host and trigger pin source facing the capture counter.
`timescale 1ns/1ps
`default_nettype none

module etc_host_model (
    // Clock
    input wire logic clk,
    // Pins and read strobes toward the counter
    output logic [3:0] trigger_pins,
    output logic serial_chip_select_n,
    output logic lsb_read_strobe,
    output logic msb_read_strobe
);
    // Chip select idles high, where its pull-up leaves it between frames.
    initial
    begin
        trigger_pins = 4'h0;
        serial_chip_select_n = 1'h1;
        lsb_read_strobe = 1'h0;
        msb_read_strobe = 1'h0;
    end

    task automatic frame(input logic msb, input logic lsb);
        @(posedge clk) serial_chip_select_n <= 1'h0;
        repeat (4) @(posedge clk);
        msb_read_strobe <= msb;
        @(posedge clk) msb_read_strobe <= 1'h0;
        lsb_read_strobe <= lsb;
        @(posedge clk) lsb_read_strobe <= 1'h0;
        @(posedge clk) serial_chip_select_n <= 1'h1;
        repeat (4) @(posedge clk);
    endtask : frame

    // Levels are held well past the synchroniser delay.
    task automatic pin(input int i, input logic v);
        @(posedge clk) trigger_pins[i] <= v;
        repeat (6) @(posedge clk);
    endtask : pin
endmodule : etc_host_model

`default_nettype wire

// >>> etc_capture_counter_tb.sv
// Self-checking testbench of the elapsed time capture counter.
`timescale 1ns/1ps
`default_nettype none

module etc_capture_counter_tb;
    logic clk, rst_n, count_enable_bit, trigger_source_select, counter_vco_select;
    logic serial_chip_select_n, lsb_read_strobe, msb_read_strobe;
    logic capture_held, capture_pulse, counter_tick;
    logic [3:0] trigger_pins, pin_polarity_invert;
    logic [3:0][5:0] pin_function_select;
    logic [39:0] captured_count_field, elapsed_time_counter, a;
    logic [4:0][7:0] captured_count_bytes;
    int fails = 0, n_tests = 0, ncap = 0;

    etc_capture_counter etc_capture_counter_inst (.clk, .rst_n, .count_enable_bit,
        .trigger_source_select, .counter_vco_select, .trigger_pins, .pin_function_select,
        .pin_polarity_invert, .serial_chip_select_n, .lsb_read_strobe, .msb_read_strobe,
        .captured_count_field, .captured_count_bytes, .elapsed_time_counter,
        .capture_held, .capture_pulse, .counter_tick);
    etc_host_model etc_host_model_inst (.clk, .trigger_pins, .serial_chip_select_n,
        .lsb_read_strobe, .msb_read_strobe);

    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    // Sampled on the falling edge so the one-cycle pulse is never raced.
    always @(negedge clk) if (capture_pulse === 1'h1) ncap++;

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    task automatic t_off;
        etc_host_model_inst.frame(1'h0, 1'h0);
        chk(elapsed_time_counter, 40'h0);
        chk(40'(ncap), 40'h0);
    endtask : t_off

    // Counter is cleared by dropping the enable before each rate check.
    task automatic t_rate(input logic v, input int n);
        int k;
        @(posedge clk) count_enable_bit <= 1'h0;
        counter_vco_select <= v;
        @(posedge clk) count_enable_bit <= 1'h1;
        // Start off the edge, so the count left by an earlier run is never read here.
        @(negedge clk);
        for (k = 0; k < 40 && elapsed_time_counter !== 40'h1; k++)
            @(negedge clk);
        chk(40'(k), 40'(n));
    endtask : t_rate

    // Falls 81 cycles apart at divide-by-8 capture counts 1 and 11.
    task automatic t_cs;
        etc_host_model_inst.frame(1'h0, 1'h0);
        a = captured_count_field;
        repeat (69) @(posedge clk);
        etc_host_model_inst.frame(1'h0, 1'h0);
        chk(captured_count_field - a, 40'hA);
        chk(captured_count_field, 40'hB);
        chk(captured_count_bytes[4], 40'hB);
        chk(captured_count_bytes[0], 40'h0);
    endtask : t_cs

    task automatic t_lock;
        int c;
        etc_host_model_inst.frame(1'h1, 1'h0);
        chk(capture_held, 1'h1);
        c = ncap;
        etc_host_model_inst.frame(1'h0, 1'h1);
        chk(40'(ncap - c), 40'h0);
        etc_host_model_inst.frame(1'h1, 1'h1);
        chk(40'(ncap - c), 40'h1);
        chk(capture_held, 1'h0);
    endtask : t_lock

    task automatic t_pin;
        int c;
        @(posedge clk) trigger_source_select <= 1'h1;
        pin_function_select <= {6'h27, 6'h27, 6'h26, 6'h00};
        pin_polarity_invert <= 4'h8;
        c = ncap;
        etc_host_model_inst.pin(1, 1'h1);
        etc_host_model_inst.frame(1'h0, 1'h0);
        chk(40'(ncap - c), 40'h0);
        etc_host_model_inst.pin(2, 1'h1);
        etc_host_model_inst.pin(2, 1'h0);
        etc_host_model_inst.pin(2, 1'h1);
        chk(40'(ncap - c), 40'h1);
        chk(capture_held, 1'h1);
        etc_host_model_inst.frame(1'h0, 1'h1);
        etc_host_model_inst.pin(3, 1'h1);
        etc_host_model_inst.pin(3, 1'h0);
        chk(40'(ncap - c), 40'h2);
    endtask : t_pin

    initial
    begin
        {rst_n, count_enable_bit, trigger_source_select, counter_vco_select} = 4'h0;
        pin_polarity_invert = 4'h0;
        pin_function_select = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        t_off();
        t_rate(1'h1, 20);
        t_rate(1'h0, 8);
        t_cs();
        t_lock();
        t_pin();
        end_sim();
    end

    // The tests need about 250 cycles; 4000 leaves a wide margin.
    initial
    begin
        #160000;
        fails++;
        end_sim();
    end
endmodule : etc_capture_counter_tb

`default_nettype wire
